// ===== hw/mbr_ctrl.sv
// Notes on behaviour
// R1: With broadcast_reject set, every received frame addressed to all stations is discarded.
// R2: With broadcast_reject clear, every received broadcast frame is forwarded.
// R3: With wake_frame_enable set, a broadcast wake frame raises wake-up whatever broadcast_reject is.
// R4: With single_attempt set, each frame gets exactly one attempt and no retransmission.
// R5: In single-attempt mode a collision abandons the frame and the next frame may start.
// R6: A frame abandoned that way reports a retry error in its transmit status.
// R7: With single_attempt clear, a colliding frame gets up to 16 attempts before a retry error.
// R8: With pad_strip_enable set, pad bytes go from frames whose length field is below 46.
// R9: Whenever pad is stripped, the trailing 4-byte frame check sequence goes too.
// R10: With pad_strip_enable set, frames with a length of 46 or more pass whole, check kept.
// R11: With pad_strip_enable clear, every frame passes whole, pad and check included.
// R12: Software never sets pad_strip_enable and rx_checksum_offload_enable together.
// R13: A length/type value of 0x0600 or more is a type and is never pad stripped.
`timescale 1ns/1ps
module mbr_ctrl
    import mbr_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Configuration bits
    input  wire logic       broadcast_reject,
    input  wire logic       single_attempt,
    input  wire logic       pad_strip_enable,
    input  wire logic       wake_frame_enable,
    input  wire logic       rx_checksum_offload_enable,
    // Receive byte stream from the MAC, contiguous within a frame
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_sof,
    input  wire logic       rx_eof,
    input  wire logic       rx_wake_match,
    // Receive byte stream to the application
    output logic            out_valid_q,
    output logic [7:0]      out_data_q,
    output logic            out_sof_q,
    output logic            out_eof_q,
    output logic            wake_event_q,
    // Transmit attempt control
    input  wire logic       tx_frame_ready,
    input  wire logic       tx_collision,
    input  wire logic       tx_complete,
    output logic            tx_go_q,
    output logic            tx_status_valid_q,
    output logic            tx_retry_error_q,
    output logic [4:0]      tx_attempts_q
);

    ////////////////////////////////////////////////////////////////////////
    // Six-byte lookahead so the destination is known at the first byte

    mbr_beat_if beat_bus ();

    mbr_pipe u_pipe (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (beat_bus.store)
    );

    always_comb begin
        beat_bus.in_beat.valid = rx_valid;
        beat_bus.in_beat.sof   = rx_valid & rx_sof;
        beat_bus.in_beat.eof   = rx_valid & rx_eof;
        beat_bus.in_beat.wake  = rx_wake_match;
        beat_bus.in_beat.data  = rx_data;
    end

    // Runts shorter than the address never count as broadcast
    function automatic logic is_broadcast(input mbr_taps_t t);
        logic ok;
        ok = t[MBR_PIPE_DEPTH-1].sof;
        for (int k = 0; k < MBR_PIPE_DEPTH; k++) begin
            ok = ok & t[k].valid & (t[k].data == MBR_BROADCAST_REJECT_BYTE);
            if (k > 0) begin
                ok = ok & ~t[k].eof;
            end
        end
        return ok;
    endfunction

    mbr_beat_t   head;
    logic        head_broadcast_reject;
    logic        frame_broadcast_reject;
    logic        frame_drop;
    logic [15:0] cur_idx;
    logic [15:0] len_now;
    logic        eligible_now;
    logic        strip_now;
    logic [15:0] keep_lim;
    logic        drop_pad;
    logic        last_kept;

    logic        broadcast_reject_q;
    logic        drop_q;
    logic [15:0] idx_q;
    logic [7:0]  len_hi_q;
    logic        eligible_q;
    logic [15:0] keep_lim_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive decisions at the output stage

    always_comb begin
        head       = beat_bus.tap[MBR_PIPE_DEPTH-1];
        head_broadcast_reject = is_broadcast(beat_bus.tap);
        cur_idx    = head.sof ? 16'h0000 : idx_q;
        frame_broadcast_reject = head.sof ? head_broadcast_reject : broadcast_reject_q;
        frame_drop  = head.sof ? (broadcast_reject & head_broadcast_reject) : drop_q; // [R1] [R2]
        len_now    = {len_hi_q, head.data};
        eligible_now = pad_strip_enable & (len_now < MBR_TYPE_MIN)     // [R13]
                     & (len_now < MBR_MIN_PAYLOAD);                  // [R8] [R10] [R11]
        strip_now  = (cur_idx == MBR_LEN_LO_IDX) ? eligible_now : eligible_q;
        keep_lim   = (cur_idx == MBR_LEN_LO_IDX) ? 16'(MBR_LEN_LO_IDX + len_now) : keep_lim_q;
        // Everything past the payload is pad then check sequence
        drop_pad   = strip_now & (cur_idx > keep_lim);               // [R8] [R9]
        last_kept  = strip_now & (cur_idx == keep_lim);              // [R9]
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            broadcast_reject_q <= 1'b0;
            drop_q  <= 1'b0;
        end else if (head.valid && head.sof) begin
            broadcast_reject_q <= head_broadcast_reject;
            drop_q  <= broadcast_reject & head_broadcast_reject;                // [R1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            idx_q <= 16'h0000;
        end else if (head.valid) begin
            idx_q <= (cur_idx == MBR_IDX_MAX) ? cur_idx : 16'(cur_idx + 16'h0001);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            len_hi_q   <= 8'h00;
            eligible_q <= 1'b0;
            keep_lim_q <= 16'h0000;
        end else if (head.valid) begin
            if (head.sof) begin
                eligible_q <= 1'b0;
            end
            if (cur_idx == MBR_LEN_HI_IDX) begin
                len_hi_q <= head.data;
            end
            if (cur_idx == MBR_LEN_LO_IDX) begin
                eligible_q <= eligible_now;
                keep_lim_q <= keep_lim;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_valid_q <= 1'b0;
            out_data_q  <= 8'h00;
            out_sof_q   <= 1'b0;
            out_eof_q   <= 1'b0;
        end else begin
            out_valid_q <= head.valid & ~frame_drop & ~drop_pad;     // [R1] [R2] [R8]
            out_data_q  <= head.data;
            out_sof_q   <= head.valid & head.sof & ~frame_drop;     // [R1]
            out_eof_q   <= head.valid & ~frame_drop & ~drop_pad & (head.eof | last_kept); // [R9]
        end
    end

    // Wake filter verdict rides with the last byte
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wake_event_q <= 1'b0;
        end else begin
            wake_event_q <= head.valid & head.eof & head.wake
                          & wake_frame_enable & frame_broadcast_reject;         // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit attempt sequencer

    mbr_tx_state_t state_q;
    mbr_tx_state_t state_d;
    logic          mode_single_q;
    logic          give_up;

    // Mode is frozen per frame so a mid-frame write cannot skew the count
    always_comb begin
        give_up = mode_single_q | (tx_attempts_q == MBR_MAX_ATTEMPTS); // [R4] [R7]
        state_d = state_q;
        unique case (state_q)
            MBR_TX_IDLE: begin
                if (tx_frame_ready) begin
                    state_d = MBR_TX_ATTEMPT;
                end
            end
            MBR_TX_ATTEMPT: begin
                state_d = MBR_TX_WAIT;
            end
            MBR_TX_WAIT: begin
                if (tx_collision) begin
                    state_d = give_up ? MBR_TX_REPORT : MBR_TX_ATTEMPT; // [R5] [R7]
                end else if (tx_complete) begin
                    state_d = MBR_TX_REPORT;
                end
            end
            MBR_TX_REPORT: begin
                state_d = MBR_TX_IDLE;                               // [R5]
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= MBR_TX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_single_q <= 1'b0;
            tx_attempts_q <= 5'h00;
        end else if (state_q == MBR_TX_IDLE && tx_frame_ready) begin
            mode_single_q <= single_attempt;
            tx_attempts_q <= 5'h00;
        end else if (state_q == MBR_TX_ATTEMPT) begin
            tx_attempts_q <= 5'(tx_attempts_q + 5'h01);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_go_q           <= 1'b0;
            tx_status_valid_q <= 1'b0;
            tx_retry_error_q  <= 1'b0;
        end else begin
            tx_go_q           <= (state_q == MBR_TX_ATTEMPT);
            tx_status_valid_q <= (state_q == MBR_TX_REPORT);
            if (state_q == MBR_TX_WAIT && state_d == MBR_TX_REPORT) begin
                tx_retry_error_q <= tx_collision;                    // [R6] [R7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_broadcast_reject_drop;
        head.valid && head.sof && head_broadcast_reject && broadcast_reject |=> !out_valid_q;
    endproperty
    a_broadcast_reject_drop: assert property (p_broadcast_reject_drop) else $error("broadcast frame passed"); // [R1]

    property p_broadcast_reject_pass;
        head.valid && head.sof && head_broadcast_reject && !broadcast_reject
            |=> out_valid_q && out_sof_q && out_data_q == MBR_BROADCAST_REJECT_BYTE;
    endproperty
    a_broadcast_reject_pass: assert property (p_broadcast_reject_pass) else $error("broadcast frame lost"); // [R2]

    property p_wake;
        head.valid && head.eof && head.wake && wake_frame_enable && frame_broadcast_reject
            |=> wake_event_q;
    endproperty
    a_wake: assert property (p_wake) else $error("wake frame missed"); // [R3]

    sequence s_single_hit;
        state_q == MBR_TX_WAIT && mode_single_q && tx_collision;
    endsequence
    sequence s_abandon;
        !tx_go_q ##1 (tx_status_valid_q && tx_retry_error_q && tx_attempts_q == 5'h01);
    endsequence
    property p_single;
        s_single_hit |=> s_abandon;
    endproperty
    a_single: assert property (p_single) else $error("single attempt retried"); // [R4] [R5] [R6]

    property p_retry;
        state_q == MBR_TX_WAIT && !mode_single_q && tx_collision
            && tx_attempts_q < MBR_MAX_ATTEMPTS |=> ##1 tx_go_q;
    endproperty
    a_retry: assert property (p_retry) else $error("retry not attempted"); // [R7]

    property p_retry_limit;
        tx_status_valid_q && tx_retry_error_q && !mode_single_q
            |-> tx_attempts_q == MBR_MAX_ATTEMPTS;
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("retry count wrong"); // [R7]

    property p_pad_gone;
        head.valid && drop_pad |=> !out_valid_q;
    endproperty
    a_pad_gone: assert property (p_pad_gone) else $error("pad byte delivered"); // [R8] [R9]

    property p_pad_end;
        head.valid && last_kept && !frame_drop |=> out_valid_q && out_eof_q;
    endproperty
    a_pad_end: assert property (p_pad_end) else $error("frame end misplaced"); // [R9]

    property p_whole;
        head.valid && !frame_drop && !strip_now
            |=> out_valid_q && out_data_q == $past(head.data) && out_eof_q == $past(head.eof);
    endproperty
    a_whole: assert property (p_whole) else $error("unstripped frame altered"); // [R10] [R11]

    property p_type;
        head.valid && cur_idx == MBR_LEN_LO_IDX && len_now >= MBR_TYPE_MIN
            |=> !eligible_q;
    endproperty
    a_type: assert property (p_type) else $error("type frame stripped"); // [R13]

endmodule

// ===== hw/mbr_pkg.sv
package mbr_pkg;

    // Receive path geometry
    localparam int          MBR_PIPE_DEPTH  = 6;
    localparam logic [15:0] MBR_LEN_HI_IDX  = 16'h000C;
    localparam logic [15:0] MBR_LEN_LO_IDX  = 16'h000D;
    localparam logic [15:0] MBR_MIN_PAYLOAD = 16'h002E;
    localparam logic [15:0] MBR_TYPE_MIN    = 16'h0600;
    localparam logic [15:0] MBR_IDX_MAX     = 16'hFFFF;
    localparam logic [7:0]  MBR_BROADCAST_REJECT_BYTE  = 8'hFF;

    // Transmit attempt limit
    localparam logic [4:0]  MBR_MAX_ATTEMPTS = 5'h10;
    localparam logic [4:0]  MBR_ONE_ATTEMPT  = 5'h01;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic       wake;
        logic [7:0] data;
    } mbr_beat_t;

    typedef mbr_beat_t mbr_taps_t [MBR_PIPE_DEPTH];

    typedef enum logic [1:0] {
        MBR_TX_IDLE    = 2'h0,
        MBR_TX_ATTEMPT = 2'h1,
        MBR_TX_WAIT    = 2'h3,
        MBR_TX_REPORT  = 2'h2
    } mbr_tx_state_t;

endpackage

// ===== hw/mbr_beat_if.sv
`timescale 1ns/1ps
interface mbr_beat_if;
    import mbr_pkg::*;

    mbr_beat_t in_beat;
    mbr_taps_t tap;

    modport producer (output in_beat, input tap);
    modport store    (input in_beat, output tap);
endinterface

// ===== hw/mbr_pipe.sv
`timescale 1ns/1ps
module mbr_pipe
    import mbr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Byte store
    mbr_beat_if.store bus
);

    ////////////////////////////////////////////////////////////////////////
    // Delay line, one stage per cycle; tap[0] is the newest beat
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus.tap[0] <= '0;
        end else begin
            bus.tap[0] <= bus.in_beat;
        end
    end

    for (genvar k = 1; k < MBR_PIPE_DEPTH; k++) begin : g_stage
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                bus.tap[k] <= '0;
            end else begin
                bus.tap[k] <= bus.tap[k-1];
            end
        end
    end

endmodule

// ===== testbench/test_mac_broadcast_reject_retry_padstrip_ctrl.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module test_mac_broadcast_reject_retry_padstrip_ctrl;
    import mbr_pkg::*;

    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic       broadcast_reject = 1'b0;
    logic       single_attempt = 1'b0;
    logic       pad_strip_enable = 1'b0;
    logic       wake_frame_enable = 1'b0;
    logic       rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic       rx_sof = 1'b0;
    logic       rx_eof = 1'b0;
    logic       rx_wake_match = 1'b0;
    logic       out_valid_q;
    logic [7:0] out_data_q;
    logic       out_sof_q;
    logic       out_eof_q;
    logic       wake_event_q;
    logic       tx_frame_ready = 1'b0;
    logic       tx_collision = 1'b0;
    logic       tx_complete = 1'b0;
    logic       tx_go_q;
    logic       tx_status_valid_q;
    logic       tx_retry_error_q;
    logic [4:0] tx_attempts_q;
    int         errors = 0;
    int         cmp_count = 0;
    logic [7:0] got [$];
    int         eof_pos;
    int         wakes;
    int         sofs;
    int         eofs;
    int         sof_pos;

    always #50 sys_clk = ~sys_clk;

    mbr_ctrl dut_u (
        .sys_clk                    (sys_clk),
        .reset                      (reset),
        .broadcast_reject           (broadcast_reject),
        .single_attempt             (single_attempt),
        .pad_strip_enable           (pad_strip_enable),
        .wake_frame_enable          (wake_frame_enable),
        .rx_checksum_offload_enable (1'b0),
        .rx_valid                   (rx_valid),
        .rx_data                    (rx_data),
        .rx_sof                     (rx_sof),
        .rx_eof                     (rx_eof),
        .rx_wake_match              (rx_wake_match),
        .out_valid_q                (out_valid_q),
        .out_data_q                 (out_data_q),
        .out_sof_q                  (out_sof_q),
        .out_eof_q                  (out_eof_q),
        .wake_event_q               (wake_event_q),
        .tx_frame_ready             (tx_frame_ready),
        .tx_collision               (tx_collision),
        .tx_complete                (tx_complete),
        .tx_go_q                    (tx_go_q),
        .tx_status_valid_q          (tx_status_valid_q),
        .tx_retry_error_q           (tx_retry_error_q),
        .tx_attempts_q              (tx_attempts_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are settled by the falling edge
    always @(negedge sys_clk) begin
        if (out_valid_q === 1'b1) begin
            got.push_back(out_data_q);
            if (out_sof_q === 1'b1) begin
                sof_pos = got.size();
            end
            if (out_eof_q === 1'b1) begin
                eof_pos = got.size();
            end
        end
        // Markers are counted even without valid, so a stray one shows up
        if (out_sof_q === 1'b1) begin
            sofs++;
        end
        if (out_eof_q === 1'b1) begin
            eofs++;
        end
        if (wake_event_q === 1'b1) begin
            wakes++;
        end
    end

    function automatic logic [7:0] frame_byte(input logic bc, input logic [15:0] lf, input int i);
        if (i < 6) begin
            return bc ? MBR_BROADCAST_REJECT_BYTE : 8'h02;
        end
        if (i == 12) begin
            return lf[15:8];
        end
        if (i == 13) begin
            return lf[7:0];
        end
        return i[7:0];
    endfunction

    task automatic rx_case(input logic bc, input logic [15:0] lf, input int n, input logic wk,
                           input int exp_n, input int exp_w);
        got.delete();
        eof_pos = 0;
        wakes = 0;
        sofs = 0;
        eofs = 0;
        sof_pos = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            rx_valid      = 1'b1;
            rx_data       = frame_byte(bc, lf, i);
            rx_sof        = (i == 0);
            rx_eof        = (i == n - 1);
            rx_wake_match = wk && (i == n - 1);
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_wake_match = 1'b0;
        repeat (10) @(negedge sys_clk);
        `CHK(got.size(), exp_n)
        `CHK(wakes, exp_w)
        `CHK(sofs, (exp_n > 0))
        `CHK(eofs, (exp_n > 0))
        if (exp_n > 0) begin
            `CHK(got[0], frame_byte(bc, lf, 0))
            `CHK(sof_pos, 1)
            `CHK(got[exp_n - 1], frame_byte(bc, lf, exp_n - 1))
            `CHK(eof_pos, exp_n)
        end
    endtask

    // Go pulses answered with collisions until ncoll is spent, then completion
    task automatic tx_case(input logic single, input int ncoll, input logic exp_err,
                           input logic [4:0] exp_att);
        int gos;
        int colls;
        int t;
        gos = 0;
        colls = 0;
        t = 0;
        @(negedge sys_clk);
        single_attempt = single;
        tx_frame_ready = 1'b1;
        @(negedge sys_clk);
        tx_frame_ready = 1'b0;
        while (tx_status_valid_q !== 1'b1 && t < 200) begin
            tx_collision = (tx_go_q === 1'b1) && (colls < ncoll);
            tx_complete  = (tx_go_q === 1'b1) && (colls >= ncoll);
            if (tx_go_q === 1'b1) begin
                gos++;
                colls++;
            end
            t++;
            @(negedge sys_clk);
        end
        tx_collision = 1'b0;
        tx_complete = 1'b0;
        `CHK(tx_status_valid_q, 1'b1)
        `CHK(tx_retry_error_q, exp_err)
        `CHK(tx_attempts_q, exp_att)
        `CHK(gos, exp_att)
    endtask

    task automatic final_report();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 20000);
        errors++;
        final_report();
    end

    initial begin
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        broadcast_reject = 1'b1;
        rx_case(1'b1, 16'h0040, 20, 1'b0, 0, 0);
        rx_case(1'b0, 16'h0040, 20, 1'b0, 20, 0);
        broadcast_reject = 1'b0;
        rx_case(1'b1, 16'h0040, 20, 1'b0, 20, 0);
        wake_frame_enable = 1'b1;
        broadcast_reject = 1'b1;
        rx_case(1'b1, 16'h0040, 20, 1'b1, 0, 1);
        broadcast_reject = 1'b0;
        rx_case(1'b1, 16'h0040, 20, 1'b1, 20, 1);
        rx_case(1'b0, 16'h0040, 20, 1'b1, 20, 0);
        wake_frame_enable = 1'b0;
        rx_case(1'b1, 16'h0040, 20, 1'b1, 20, 0);
        pad_strip_enable = 1'b1;
        rx_case(1'b0, 16'h000A, 64, 1'b0, 24, 0);
        rx_case(1'b0, 16'h002D, 64, 1'b0, 59, 0);
        rx_case(1'b0, 16'h002E, 64, 1'b0, 64, 0);
        rx_case(1'b0, 16'h0600, 64, 1'b0, 64, 0);
        rx_case(1'b0, 16'h0800, 64, 1'b0, 64, 0);
        pad_strip_enable = 1'b0;
        rx_case(1'b0, 16'h000A, 64, 1'b0, 64, 0);
        tx_case(1'b1, 1, 1'b1, 5'h01);
        tx_case(1'b1, 0, 1'b0, 5'h01);
        tx_case(1'b0, 16, 1'b1, MBR_MAX_ATTEMPTS);
        tx_case(1'b0, 3, 1'b0, 5'h04);
        tx_case(1'b1, 1, 1'b1, 5'h01);
        final_report();
    end
endmodule
